// ### verif/spz_properties.sv
`timescale 1ns/1ps
module spz_props
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic        txd
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer moved");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer moved");
    property p_r_high;
        rvalid |-> rdata[31:8] == 24'h0;
    endproperty
    a_r_high: assert property (p_r_high) else $error("read upper bits set");
    property p_r_done;
        rvalid && rready |=> !rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read answer repeated");
    property p_b_lat;
        awvalid && awready && wvalid && wready |-> ##2 bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_r_lat;
        arvalid && arready |=> rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_resp;
        (bvalid |-> bresp inside {2'b00, 2'b10}) and (rvalid |-> rresp inside {2'b00, 2'b10});
    endproperty
    a_resp: assert property (p_resp) else $error("bad response code");
    // a low bit is never shorter than two clocks in any mode
    property p_start;
        $fell(txd) |=> !txd;
    endproperty
    a_start: assert property (p_start) else $error("low bit too short");
    c_wr: cover property (bvalid && bready);
    c_rd: cover property (rvalid && rready);
    c_tx: cover property ($fell(txd));
endmodule

bind spz_top spz_props u_props
(
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
    .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .txd
);

// ### verif/spz_remote.sv
`timescale 1ns/1ps
module spz_remote
(
    input  wire logic aclk,
    input  wire logic txd,
    output logic      line
);
    initial line = 1'b1;
    // start, bits lsb first, stop, then idle high
    task automatic send(input logic [8:0] d, input int nb, input logic st, input int per);
        int i;
        line <= 1'b0;
        repeat (per) @(posedge aclk);
        for (i = 0; i < nb; i++)
        begin
            line <= d[i];
            repeat (per) @(posedge aclk);
        end
        line <= st;
        repeat (per) @(posedge aclk);
        line <= 1'b1;
        repeat (per) @(posedge aclk);
    endtask
    // samples mid bit; the last bit kept is the stop
    task automatic get(output logic [9:0] d, input int nb, input int per, output bit ok);
        int i;
        d = 10'h0;
        for (i = 0; i < 4000 && txd; i++)
            @(posedge aclk);
        ok = i < 4000;
        repeat (per / 2) @(posedge aclk);
        ok = ok && !txd;
        for (i = 0; i <= nb; i++)
        begin
            repeat (per) @(posedge aclk);
            d[i] = txd;
        end
        // let the stop bit finish so the sender is idle again
        repeat (per / 2 + 4) @(posedge aclk);
    endtask
endmodule

// ### verif/spz_top_tb.sv
`timescale 1ns/1ps
`include "spz_params.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; $display("CHECK FAILED %0t %h %h", $time, (a), (e)); end end
module spz_top_tb;
    localparam logic [11:0] A_CTRL  = {`SPZ_IDX_CTRL, 2'b00};
    localparam logic [11:0] A_BUF   = {`SPZ_IDX_BUF, 2'b00};
    localparam logic [11:0] A_PCTL  = {`SPZ_IDX_PCTL, 2'b00};
    localparam logic [11:0] A_SLAVE_ADDRESS_MASK = {`SPZ_IDX_SLAVE_ADDRESS_MASK, 2'b00};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = 12'h0;
    logic [11:0] araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        baud_tick = 1'b0, rate_double = 1'b1;
    logic        awready, wready, bvalid, arready, rvalid, rxd_out, rxd_oe, txd, line;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [9:0]  got;
    logic [7:0]  eb;
    bit          ok;
    int          failures = 0;
    int          checked = 0;
    int          j;
    logic [8:0]  fr [5] = '{9'h05a, 9'h15a, 9'h1a5, 9'h153, 9'h1c3};
    logic        acc [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

    always #20 aclk = ~aclk;
    // tick every other clock, so a bit is 32 clocks
    always @(posedge aclk) baud_tick <= ~baud_tick;

    spz_top dut
    (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .baud_tick, .rate_double, .rxd_in(line), .rxd_out, .rxd_oe, .txd
    );
    spz_remote rem (.aclk, .txd, .line);

    task automatic final_report(input bit hung);
        if (hung)
            failures++;
        if (failures == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        int i;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
        `CHK(bresp, er)
        if (i == 50)
            final_report(1);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
        int i;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rready <= 1'b0;
        `CHK(rdata & m, e)
        `CHK(rresp, er)
        if (i == 50)
            final_report(1);
    endtask
    // done flag must still be low just after the buffer write
    task automatic txf(input logic [7:0] d, input int nb, input logic [9:0] e);
        fork
            rem.get(got, nb, 32, ok);
            begin
                wr(A_BUF, d, 2'b00);
                rc(A_CTRL, 32'h2, 32'h0, 2'b00);
            end
        join
        `CHK(ok, 1'b1)
        `CHK(got, e)
        if (!ok)
            final_report(0);
    endtask

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rc(A_CTRL, 32'hff, 32'h0, 2'b00);
        rc(12'h100, 32'h0, 32'h0, 2'b10);
        wr(12'h100, 8'h55, 2'b10);
        wr(A_CTRL, 8'h50, 2'b00);
        txf(8'ha5, 8, 10'h1a5);
        rc(A_CTRL, 32'hff, 32'h52, 2'b00);
        wr(A_CTRL, 8'h50, 2'b00);
        rem.send(9'h03c, 8, 1'b1, 32);
        rc(A_CTRL, 32'hff, 32'h55, 2'b00);
        rc(A_BUF, 32'hff, 32'h3c, 2'b00);
        wr(A_CTRL, 8'h40, 2'b00);
        rem.send(9'h011, 8, 1'b1, 32);
        rc(A_CTRL, 32'hff, 32'h44, 2'b00);
        rc(A_BUF, 32'hff, 32'h3c, 2'b00);
        wr(A_PCTL, 8'h40, 2'b00);
        wr(A_CTRL, 8'h70, 2'b00);
        rem.send(9'h077, 8, 1'b0, 32);
        rc(A_CTRL, 32'hff, 32'hf4, 2'b00);
        wr(A_CTRL, 8'h70, 2'b00);
        rem.send(9'h066, 8, 1'b1, 32);
        rc(A_CTRL, 32'hff, 32'h75, 2'b00);
        wr(A_PCTL, 8'h00, 2'b00);
        rc(A_CTRL, 32'h80, 32'h0, 2'b00);
        wr({`SPZ_IDX_SLAVE_ADDRESS, 2'b00}, 8'h5a, 2'b00);
        wr(A_SLAVE_ADDRESS_MASK, 8'hf0, 2'b00);
        eb = 8'h66;
        for (j = 0; j < 5; j++)
        begin
            if (j == 4)
                wr(A_SLAVE_ADDRESS_MASK, 8'h00, 2'b00);
            wr(A_CTRL, 8'hf0, 2'b00);
            rem.send(fr[j], 9, 1'b1, 32);
            eb = acc[j] ? fr[j][7:0] : eb;
            rc(A_CTRL, 32'h1, {31'h0, acc[j]}, 2'b00);
            rc(A_BUF, 32'hff, {24'h0, eb}, 2'b00);
        end
        for (j = 0; j < 2; j++)
        begin
            wr(A_CTRL, j ? 8'hc8 : 8'hc0, 2'b00);
            txf(8'h81, 9, {1'b1, j[0], 8'h81});
            rc(A_CTRL, 32'h2, 32'h2, 2'b00);
        end
        for (j = 0; j < 2; j++)
        begin
            rate_double <= j[0];
            wr(A_CTRL, 8'h90, 2'b00);
            eb = j ? 8'h18 : 8'he7;
            rem.send({~j[0], eb}, 9, 1'b1, j ? 32 : 64);
            rc(A_BUF, 32'hff, {24'h0, eb}, 2'b00);
            rc(A_CTRL, 32'h5, {29'h0, ~j[0], 2'b01}, 2'b00);
        end
        // mode 0 fast clock: data out is caught at each shift clock rise
        wr(A_CTRL, 8'h20, 2'b00);
        wr(A_BUF, 8'hc5, 2'b00);
        ok = 1'b1;
        for (j = 0; j < 40; j++)
        begin
            @(posedge aclk);
            if (txd && !ok)
            begin
                eb = {rxd_out, eb[7:1]};
                `CHK(rxd_oe, 1'b1)
            end
            ok = txd;
        end
        `CHK(eb, 8'hc5)
        `CHK(rxd_oe, 1'b0)
        rc(A_CTRL, 32'h2, 32'h2, 2'b00);
        final_report(0);
    end
endmodule

// ### verilog/spz_axil.sv
`timescale 1ns/1ps
`include "spz_params.svh"
module spz_axil
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             reg_wr,
    output logic [9:0]       reg_widx,
    output logic [7:0]       reg_wdata,
    output logic [9:0]       reg_ridx,
    input  wire logic [7:0]  reg_rdata
);
    logic       aw_full;
    logic       w_full;
    logic       w_lane0;
    logic       fire;

    function automatic logic spz_hit(input logic [9:0] idx);
        return idx == `SPZ_IDX_CTRL || idx == `SPZ_IDX_BUF || idx == `SPZ_IDX_SLAVE_ADDRESS
            || idx == `SPZ_IDX_PCTL || idx == `SPZ_IDX_SLAVE_ADDRESS_MASK;
    endfunction

    assign awready  = !aw_full;
    assign wready   = !w_full;
    assign arready  = !rvalid;
    assign reg_ridx = araddr[11:2];
    // address and data are held apart so they may arrive in either order
    assign fire     = aw_full && w_full && !bvalid;
    // only lane 0 carries register bits
    assign reg_wr   = fire && w_lane0 && spz_hit(reg_widx);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full  <= 1'b0;
            reg_widx <= 10'h000;
        end
        else if (awvalid && awready)
        begin
            aw_full  <= 1'b1;
            reg_widx <= awaddr[11:2];
        end
        else if (fire)
            aw_full <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_full    <= 1'b0;
            w_lane0   <= 1'b0;
            reg_wdata <= 8'h00;
        end
        else if (wvalid && wready)
        begin
            w_full    <= 1'b1;
            w_lane0   <= wstrb[0];
            reg_wdata <= wdata[7:0];
        end
        else if (fire)
            w_full <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= 2'b00;
        end
        else if (fire)
        begin
            bvalid <= 1'b1;
            bresp  <= spz_hit(reg_widx) ? 2'b00 : 2'b10;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= 2'b00;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rdata  <= {24'h000000, reg_rdata};
            rresp  <= spz_hit(reg_ridx) ? 2'b00 : 2'b10;
        end
        else if (rready)
            rvalid <= 1'b0;
    end
endmodule

// ### verilog/spz_params.svh
`ifndef SPZ_PARAMS_SVH
`define SPZ_PARAMS_SVH

// register indices; byte address is four times the index
`define SPZ_IDX_CTRL  10'h098
`define SPZ_IDX_BUF   10'h099
`define SPZ_IDX_SLAVE_ADDRESS 10'h09a
`define SPZ_IDX_PCTL  10'h09b
`define SPZ_IDX_SLAVE_ADDRESS_MASK 10'h0b9

// serial_control field positions
`define SPZ_B_SM0FE 7
`define SPZ_B_SM1   6
`define SPZ_B_SM2   5
`define SPZ_B_REN   4
`define SPZ_B_TB8   3
`define SPZ_B_RB8   2
`define SPZ_B_TI    1
`define SPZ_B_RI    0
// power_control field position
`define SPZ_B_FEVS  6

`define SPZ_RST_REG 8'h00

// clocks per bit and oversampling
`define SPZ_M0_SLOW 12
`define SPZ_M0_FAST 4
`define SPZ_M2_SLOW 64
`define SPZ_M2_FAST 32
`define SPZ_OSR     16

`endif

// ### verilog/spz_pkg.sv
package spz_pkg;

    typedef enum logic [1:0]
    {
        spz_mode0 = 2'b00,
        spz_mode1 = 2'b01,
        spz_mode2 = 2'b10,
        spz_mode3 = 2'b11
    } spz_mode_t;

    typedef enum logic [5:0]
    {
        spz_tx_idle  = 6'b000001,
        spz_tx_start = 6'b000010,
        spz_tx_data  = 6'b000100,
        spz_tx_ninth = 6'b001000,
        spz_tx_stop  = 6'b010000,
        spz_tx_sync  = 6'b100000
    } spz_tx_st_t;

    typedef enum logic [4:0]
    {
        spz_rx_idle  = 5'b00001,
        spz_rx_start = 5'b00010,
        spz_rx_data  = 5'b00100,
        spz_rx_ninth = 5'b01000,
        spz_rx_stop  = 5'b10000
    } spz_rx_st_t;

endpackage

// ### verilog/spz_top.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "spz_params.svh"
// Notes on behaviour
// - control top bit: mode bit or frame error
// - frame error set on bad stop, software clears
// - mode bits pick one of four frame modes
// - modes 2/3 multiproc: ninth bit 0 drops
// - mode 1 multiproc: bad stop drops frame
// - mode 0 multiproc bit picks clock divide
// - receive only while receive enable set
// - modes 2/3 send tx ninth bit
// - rx ninth bit: ninth bit, or stop in mode 1 with multiproc clear
// - tx done timing, software clears
// - rx done timing, software clears
// - buffer: read receive, write transmit
// - masked compare against slave address
// - all-zero mask accepts any address
module spz_top
#(
    parameter int OSR = `SPZ_OSR
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        baud_tick,
    input  wire logic        rate_double,
    input  wire logic        rxd_in,
    output logic             rxd_out,
    output logic             rxd_oe,
    output logic             txd
);
    localparam int CW = $clog2(OSR);
    localparam logic [CW-1:0] MID = CW'(OSR / 2 - 1);
    localparam logic [CW-1:0] LAST = CW'(OSR - 1);
    localparam logic [5:0] D0S = 6'(`SPZ_M0_SLOW / 2);
    localparam logic [5:0] D0F = 6'(`SPZ_M0_FAST / 2);
    localparam logic [5:0] D2S = 6'(`SPZ_M2_SLOW / OSR);
    localparam logic [5:0] D2F = 6'(`SPZ_M2_FAST / OSR);

    generate
        if (OSR < 4 || OSR > `SPZ_M2_FAST || (OSR & (OSR - 1)) != 0)
            $error("OSR must be a power of two from 4 to 32");
    endgenerate

    logic                 reg_wr;
    logic [9:0]           reg_widx;
    logic [7:0]           reg_wdata;
    logic [9:0]           reg_ridx;
    logic [7:0]           reg_rdata;
    logic                 sm0, sm1, sm2, ren, tb8, rb8, ti, ri, fe, fevs;
    logic [7:0]           rx_buf, tx_buf, slave_address, slave_address_mask;
    spz_pkg::spz_mode_t   mode;
    spz_pkg::spz_tx_st_t  tx_st;
    spz_pkg::spz_rx_st_t  rx_st;
    logic [5:0]           div_cnt, div_lim;
    logic                 div_tick, tick16;
    logic [CW-1:0]        tx_cnt, rx_cnt;
    logic [2:0]           tx_bit, rx_bit;
    logic [7:0]           tx_sh, rx_sh;
    logic                 m0_ph, m0_rx, tx_go, ti_set, ri_set, fe_set;
    logic                 rx_s1, rx_s2, rx_s3, rx_mid, rx_r9;
    logic                 stop_ok, accept, addr_ok, rb8_load;
    logic                 next_txd, next_rxd_out, next_rxd_oe;

    function automatic logic spz_nine(input spz_pkg::spz_mode_t m);
        return m == spz_pkg::spz_mode2 || m == spz_pkg::spz_mode3;
    endfunction

    spz_axil u_bus
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .awaddr    (awaddr),
        .awvalid   (awvalid),
        .awready   (awready),
        .wdata     (wdata),
        .wstrb     (wstrb),
        .wvalid    (wvalid),
        .wready    (wready),
        .bresp     (bresp),
        .bvalid    (bvalid),
        .bready    (bready),
        .araddr    (araddr),
        .arvalid   (arvalid),
        .arready   (arready),
        .rdata     (rdata),
        .rresp     (rresp),
        .rvalid    (rvalid),
        .rready    (rready),
        .reg_wr    (reg_wr),
        .reg_widx  (reg_widx),
        .reg_wdata (reg_wdata),
        .reg_ridx  (reg_ridx),
        .reg_rdata (reg_rdata)
    );

    function automatic logic spz_wr(input logic wr, input logic [9:0] idx, input logic [9:0] want);
        return wr && idx == want;
    endfunction

    assign mode = spz_pkg::spz_mode_t'({sm0, sm1});

    always_comb
    begin
        reg_rdata = 8'h00;
        case (reg_ridx)
            `SPZ_IDX_CTRL:  reg_rdata = {fevs ? fe : sm0, sm1, sm2, ren, tb8, rb8, ti, ri};
            `SPZ_IDX_BUF:   reg_rdata = rx_buf;
            `SPZ_IDX_SLAVE_ADDRESS: reg_rdata = slave_address;
            `SPZ_IDX_SLAVE_ADDRESS_MASK: reg_rdata = slave_address_mask;
            `SPZ_IDX_PCTL:  reg_rdata = 8'(fevs) << `SPZ_B_FEVS;
            default:        reg_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {sm0, sm1, sm2, ren, tb8} <= 5'h00;
            fevs  <= 1'b0;
            slave_address <= `SPZ_RST_REG;
            slave_address_mask <= `SPZ_RST_REG;
        end
        else if (spz_wr(reg_wr, reg_widx, `SPZ_IDX_CTRL))
        begin
            // top bit writes the mode only in mode view
            if (!fevs)
                sm0 <= reg_wdata[`SPZ_B_SM0FE];
            sm1 <= reg_wdata[`SPZ_B_SM1];
            sm2 <= reg_wdata[`SPZ_B_SM2];
            ren <= reg_wdata[`SPZ_B_REN];
            tb8 <= reg_wdata[`SPZ_B_TB8];
        end
        else if (spz_wr(reg_wr, reg_widx, `SPZ_IDX_PCTL))
            fevs <= reg_wdata[`SPZ_B_FEVS];
        else if (spz_wr(reg_wr, reg_widx, `SPZ_IDX_SLAVE_ADDRESS))
            slave_address <= reg_wdata;
        else if (spz_wr(reg_wr, reg_widx, `SPZ_IDX_SLAVE_ADDRESS_MASK))
            slave_address_mask <= reg_wdata;
    end

    // flags: hardware set wins over a software write in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ti <= 1'b0;
            ri <= 1'b0;
            fe <= 1'b0;
        end
        else
        begin
            if (ti_set)
                ti <= 1'b1;
            else if (spz_wr(reg_wr, reg_widx, `SPZ_IDX_CTRL))
                ti <= reg_wdata[`SPZ_B_TI];
            if (ri_set)
                ri <= 1'b1;
            else if (spz_wr(reg_wr, reg_widx, `SPZ_IDX_CTRL))
                ri <= reg_wdata[`SPZ_B_RI];
            if (fe_set)
                fe <= 1'b1;
            else if (spz_wr(reg_wr, reg_widx, `SPZ_IDX_CTRL) && fevs)
                fe <= reg_wdata[`SPZ_B_SM0FE];
        end
    end

    // writes fill the transmit side and start a frame while tx_st is idle
    assign tx_go = spz_wr(reg_wr, reg_widx, `SPZ_IDX_BUF) && tx_st == spz_pkg::spz_tx_idle;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tx_buf <= `SPZ_RST_REG;
        else if (spz_wr(reg_wr, reg_widx, `SPZ_IDX_BUF))
            tx_buf <= reg_wdata;
    end

    // mode 0 half bit; mode 2 sixteenth bit
    always_comb
    begin
        if (mode == spz_pkg::spz_mode0)
            div_lim = sm2 ? D0F : D0S;
        else
            div_lim = rate_double ? D2F : D2S;
    end

    always_ff @(posedge aclk)
    begin
        // held at zero while mode 0 is idle so the first half bit is whole
        if (!aresetn || div_tick || (mode == spz_pkg::spz_mode0 && tx_st == spz_pkg::spz_tx_idle))
            div_cnt <= 6'h00;
        else
            div_cnt <= div_cnt + 6'h01;
    end

    // a lowered limit must not let the count wrap through 64
    assign div_tick = div_cnt >= div_lim - 6'h01;
    // external tick paces modes 1 and 3
    assign tick16 = mode == spz_pkg::spz_mode2 ? div_tick : (mode[0] && baud_tick);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_st  <= spz_pkg::spz_tx_idle;
            tx_cnt <= '0;
            tx_bit <= 3'h0;
            tx_sh  <= 8'h00;
            m0_ph  <= 1'b0;
            m0_rx  <= 1'b0;
        end
        else
        begin
            unique case (tx_st)
                spz_pkg::spz_tx_idle:
                    if (tx_go || (mode == spz_pkg::spz_mode0 && ren && !ri))
                    begin
                        // mode 0 reception also needs enable
                        tx_st  <= mode == spz_pkg::spz_mode0 ? spz_pkg::spz_tx_sync : spz_pkg::spz_tx_start;
                        m0_rx  <= !tx_go;
                        tx_sh  <= tx_go ? reg_wdata : tx_buf;
                        tx_cnt <= '0;
                        tx_bit <= 3'h0;
                        m0_ph  <= 1'b0;
                    end
                spz_pkg::spz_tx_sync:
                    if (div_tick)
                    begin
                        m0_ph <= !m0_ph;
                        // sample on the rising shift clock, shift on its end
                        if (!m0_ph && m0_rx)
                            tx_sh <= {rx_s2, tx_sh[7:1]};
                        else if (m0_ph && !m0_rx)
                            tx_sh <= {1'b0, tx_sh[7:1]};
                        if (m0_ph)
                        begin
                            tx_bit <= tx_bit + 3'h1;
                            if (tx_bit == 3'h7)
                                tx_st <= spz_pkg::spz_tx_idle;
                        end
                    end
                default:
                    if (tick16)
                    begin
                        tx_cnt <= tx_cnt + CW'(1);
                        if (tx_cnt == LAST)
                        begin
                            if (tx_st == spz_pkg::spz_tx_start)
                                tx_st <= spz_pkg::spz_tx_data;
                            else if (tx_st == spz_pkg::spz_tx_data)
                            begin
                                tx_sh  <= {1'b0, tx_sh[7:1]};
                                tx_bit <= tx_bit + 3'h1;
                                if (tx_bit == 3'h7)
                                    tx_st <= spz_nine(mode) ? spz_pkg::spz_tx_ninth : spz_pkg::spz_tx_stop;
                            end
                            else if (tx_st == spz_pkg::spz_tx_ninth)
                                tx_st <= spz_pkg::spz_tx_stop;
                            else
                                tx_st <= spz_pkg::spz_tx_idle;
                        end
                    end
            endcase
        end
    end

    // end of 8th bit in mode 0, stop start otherwise
    assign ti_set = (tx_st == spz_pkg::spz_tx_sync && !m0_rx && div_tick && m0_ph && tx_bit == 3'h7)
                 || (tick16 && tx_cnt == LAST && (tx_st == spz_pkg::spz_tx_ninth
                 || (tx_st == spz_pkg::spz_tx_data && tx_bit == 3'h7 && !spz_nine(mode))));

    always_comb
    begin
        next_txd     = 1'b1;
        next_rxd_out = 1'b1;
        next_rxd_oe  = 1'b0;
        unique case (tx_st)
            spz_pkg::spz_tx_sync:
            begin
                next_txd     = m0_ph;
                next_rxd_out = tx_sh[0];
                next_rxd_oe  = !m0_rx;
            end
            spz_pkg::spz_tx_start: next_txd = 1'b0;
            spz_pkg::spz_tx_data:  next_txd = tx_sh[0];
            spz_pkg::spz_tx_ninth: next_txd = tb8;
            default:               next_txd = 1'b1;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            txd     <= 1'b1;
            rxd_out <= 1'b1;
            rxd_oe  <= 1'b0;
        end
        else
        begin
            txd     <= next_txd;
            rxd_out <= next_rxd_out;
            rxd_oe  <= next_rxd_oe;
        end
    end

    // rx pin crosses in; edge detect reads only later stages
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            {rx_s1, rx_s2, rx_s3} <= 3'b111;
        else
            {rx_s1, rx_s2, rx_s3} <= {rxd_in, rx_s1, rx_s2};
    end

    assign rx_mid  = tick16 && rx_cnt == MID;
    assign stop_ok = rx_s2;
    // masked compare; zero mask matches all
    assign addr_ok = ((rx_sh ^ slave_address) & slave_address_mask) == 8'h00;
    // mode 1 needs a good stop; modes 2/3 need ninth bit and address
    assign accept  = !sm2 || (mode == spz_pkg::spz_mode1 ? stop_ok : rx_r9 && addr_ok);
    assign fe_set  = rx_st == spz_pkg::spz_rx_stop && rx_mid && !stop_ok;
    // middle of stop, or end of 8th bit in mode 0
    assign ri_set  = (rx_st == spz_pkg::spz_rx_stop && rx_mid && accept)
                  || (tx_st == spz_pkg::spz_tx_sync && m0_rx && div_tick && m0_ph && tx_bit == 3'h7);
    // ninth bit or stop; no function in mode 0
    assign rb8_load = spz_nine(mode) ? rx_r9 : stop_ok;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_buf <= `SPZ_RST_REG;
            rb8    <= 1'b0;
        end
        else if (ri_set)
        begin
            rx_buf <= tx_st == spz_pkg::spz_tx_sync ? tx_sh : rx_sh;
            if (tx_st != spz_pkg::spz_tx_sync && (spz_nine(mode) || !sm2))
                rb8 <= rb8_load;
        end
    end

    always_ff @(posedge aclk)
    begin
        // clearing the enable drops a frame in progress
        if (!aresetn || !ren || mode == spz_pkg::spz_mode0)
        begin
            rx_st  <= spz_pkg::spz_rx_idle;
            rx_cnt <= '0;
            rx_bit <= 3'h0;
            rx_sh  <= 8'h00;
            rx_r9  <= 1'b0;
        end
        else if (rx_st == spz_pkg::spz_rx_idle)
        begin
            rx_cnt <= '0;
            rx_bit <= 3'h0;
            if (rx_s3 && !rx_s2)
                rx_st <= spz_pkg::spz_rx_start;
        end
        else if (tick16)
        begin
            rx_cnt <= rx_cnt + CW'(1);
            if (rx_cnt == MID)
            begin
                unique case (rx_st)
                    // a glitch that is high at mid start is no start
                    spz_pkg::spz_rx_start:
                        rx_st <= rx_s2 ? spz_pkg::spz_rx_idle : spz_pkg::spz_rx_data;
                    spz_pkg::spz_rx_data:
                    begin
                        rx_sh  <= {rx_s2, rx_sh[7:1]};
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == 3'h7)
                            rx_st <= spz_nine(mode) ? spz_pkg::spz_rx_ninth : spz_pkg::spz_rx_stop;
                    end
                    spz_pkg::spz_rx_ninth:
                    begin
                        rx_r9 <= rx_s2;
                        rx_st <= spz_pkg::spz_rx_stop;
                    end
                    default:
                        rx_st <= spz_pkg::spz_rx_idle;
                endcase
            end
        end
    end
endmodule
